// *** design/sram_port.sv ***
// pipelined synchronous static memory seen from inside the memory device
// assumes the host drives every synchronous pin from clk_sys_in, so no
// synchroniser is used; the pad logic resolves the two-way data wires
`timescale 1ns/10ps

// Summary of operation
// RULE1: address captured only on load, clock held off, all chip selects true.
// RULE2: load with chip selected takes new address and control, starts operation.
// RULE3: load while deselected ends any running burst.
// RULE4: advance steps the burst counter and ignores the address pins.
// RULE5: read/write picked on load; its data moves two cycles later.
// RULE6: clock hold high freezes everything as if the edge never came.
// RULE7: host gives valid byte write enables on each write word.
// RULE8: byte write enables are ignored for reads.
// RULE9: enabled bytes reach the array two cycles after their enables; here the array write lands three cycles after them.
// RULE10: enables tied low write the whole 36-bit word.
// RULE11: any chip select false together with load starts a deselect.
// RULE12: data pins float two cycles after a deselect.
// RULE13: high-active chip select works like the low ones, inverted.
// RULE14: all synchronous pins act on the rising edge, output enable excepted.
// RULE15: write data and read data are both registered at the pins.
// RULE16: burst order select high means interleaved, low means linear.
// RULE17: host keeps burst order select fixed during operation.
// RULE18: output enable high floats data pins at once, without a clock.
// RULE19: host may keep output enable low; turnaround is internal.
// RULE20: one loaded address yields four words by the burst counter.
// RULE21: deselect never cancels reads or writes already in flight.
// RULE22: data pins float two cycles after a write starts.
// RULE23: counter works on low two address bits, linear add or xor.
module sram_port #(
    parameter int ADDR_W     = sram_port_pkg::ADDR_W_DEF,
    parameter int FIFO_DEPTH = sram_port_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                             clk_sys_in,
    input  wire logic                             rstn_in,
    // address and control
    input  wire logic [ADDR_W-1:0]                addr_lines_in,
    input  wire logic                             load_or_advance_in,
    input  wire logic                             read_write_in,
    input  wire logic                             clock_hold_n_in,
    input  wire logic [sram_port_pkg::LANES-1:0]  byte_write_n_in,
    input  wire logic                             chip_select_a_n_in,
    input  wire logic                             chip_select_b_n_in,
    input  wire logic                             chip_select_hi_in,
    input  wire logic                             burst_order_sel_in,
    input  wire logic                             output_enable_n_in,
    // data pins
    input  wire logic [sram_port_pkg::DATA_W-1:0] data_lines_in,
    output logic      [sram_port_pkg::DATA_W-1:0] data_lines_out,
    output logic                                  data_lines_oe_out,
    // parity pins
    input  wire logic [sram_port_pkg::LANES-1:0]  parity_lines_in,
    output logic      [sram_port_pkg::LANES-1:0]  parity_lines_out,
    output logic                                  parity_lines_oe_out
);
    import sram_port_pkg::*;

    localparam int WORDS = 1 << ADDR_W;

    if (ADDR_W <= BURST_W || ADDR_W > 24)
    begin : g_chk
        $error("sram_port: ADDR_W must be 3 to 24");
    end

    // one pipeline slot: an access waiting for its data cycle
    typedef struct packed {
        logic              vld;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  bwn;
    } stage_t;

    typedef struct packed {
        burst_t                   burst;
        logic                     rd;
        logic                     order;
        logic [ADDR_W-BURST_W-1:0] hi;
        logic [BURST_W-1:0]       base;
        logic [BURST_W-1:0]       cnt;
        stage_t                   s1;
        stage_t                   s2;
        stage_t                   wr;
        logic [WORD_W-1:0]        wdata;
        logic [WORD_W-1:0]        dout;
        logic                     drive;
    } state_t;

    state_t              st_r;
    state_t              st_nxt;
    logic [WORD_W-1:0]   mem [WORDS];
    logic [WORD_W-1:0]   pin_word;
    logic [WORD_W-1:0]   arr_word;
    logic [WORD_W-1:0]   rd_word;
    logic                selected;
    logic                push_req;
    logic                run;
    logic                s2_hit;
    logic                wr_hit;
    logic [BURST_W-1:0]  cnt_next;
    logic [BURST_W-1:0]  low_next;

    fifo_link_if #(.W(WORD_W)) rq ();

    // burst address for a given count
    function automatic logic [BURST_W-1:0] burst_low(
        input logic               order,
        input logic [BURST_W-1:0] base,
        input logic [BURST_W-1:0] cnt
    );
        logic [BURST_W-1:0] v;
        v = order ? (base ^ cnt) : (base + cnt); // RULE16 RULE23
        return v;
    endfunction : burst_low

    assign selected = !chip_select_a_n_in && !chip_select_b_n_in && chip_select_hi_in; // RULE13
    assign cnt_next = st_r.cnt + BURST_STEP;
    assign low_next = burst_low(st_r.order, st_r.base, cnt_next);

    // a read in slot one leaves the array now and waits in the buffer
    assign push_req = st_r.s1.vld && st_r.s1.rd;

    // a full buffer stalls the pipeline like the hold pin; with the
    // one-cycle spacing from push to pop it never holds more than one word
    assign run = !clock_hold_n_in && (rq.in_ready || !push_req); // RULE6

    // newer writes not yet in the array are forwarded per lane
    assign arr_word = mem[st_r.s1.addr];
    assign s2_hit   = st_r.s2.vld && !st_r.s2.rd && (st_r.s2.addr == st_r.s1.addr);
    assign wr_hit   = st_r.wr.vld && (st_r.wr.addr == st_r.s1.addr);

    for (genvar b = 0; b < LANES; b++)
    begin : g_lane
        assign pin_word[b*LANE_W +: LANE_W] = {parity_lines_in[b], data_lines_in[b*BYTE_W +: BYTE_W]};
        assign data_lines_out[b*BYTE_W +: BYTE_W] = st_r.dout[b*LANE_W +: BYTE_W];
        assign parity_lines_out[b] = st_r.dout[b*LANE_W + PAR_POS];

        assign rd_word[b*LANE_W +: LANE_W] =
            (s2_hit && !st_r.s2.bwn[b]) ? pin_word[b*LANE_W +: LANE_W] :
            (wr_hit && !st_r.wr.bwn[b]) ? st_r.wdata[b*LANE_W +: LANE_W] :
            arr_word[b*LANE_W +: LANE_W];
    end

    assign rq.in_valid  = push_req && run;
    assign rq.in_data   = rd_word;
    assign rq.out_ready = run && st_r.s2.vld && st_r.s2.rd;

    // output enable gates the pins without waiting for a clock
    assign data_lines_oe_out   = st_r.drive && !output_enable_n_in; // RULE18
    assign parity_lines_oe_out = st_r.drive && !output_enable_n_in; // RULE18

    word_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .link       (rq)
    );

    always_comb
    begin
        st_nxt = st_r;
        // without run every register keeps its value
        if (run) // RULE6 RULE14
        begin
            st_nxt.s1 = '0;
            if (!load_or_advance_in)
            begin
                if (selected)
                begin
                    st_nxt.burst   = BURST_RUN; // RULE2
                    st_nxt.rd      = read_write_in; // RULE5
                    st_nxt.order   = burst_order_sel_in; // RULE16
                    st_nxt.hi      = addr_lines_in[ADDR_W-1:BURST_W]; // RULE1
                    st_nxt.base    = addr_lines_in[BURST_W-1:0]; // RULE1
                    st_nxt.cnt     = BURST_FIRST;
                    st_nxt.s1.vld  = 1'b1;
                    st_nxt.s1.rd   = read_write_in;
                    st_nxt.s1.addr = addr_lines_in; // RULE1
                    // reads leave every lane untouched
                    st_nxt.s1.bwn  = read_write_in ? LANES_OFF : byte_write_n_in; // RULE8 RULE10
                end
                else
                begin
                    // deselect: ends the burst, slots in flight continue
                    st_nxt.burst = BURST_IDLE; // RULE3 RULE11 RULE21
                end
            end
            else if (st_r.burst == BURST_RUN)
            begin
                // address pins are not looked at here
                st_nxt.cnt     = cnt_next; // RULE4 RULE20
                st_nxt.s1.vld  = 1'b1;
                st_nxt.s1.rd   = st_r.rd;
                st_nxt.s1.addr = {st_r.hi, low_next}; // RULE23
                st_nxt.s1.bwn  = st_r.rd ? LANES_OFF : byte_write_n_in; // RULE8
            end

            // slots move on regardless of the new command
            st_nxt.s2 = st_r.s1; // RULE21

            // write data is registered from the pins two cycles on
            st_nxt.wr = st_r.s2;
            st_nxt.wr.vld = st_r.s2.vld && !st_r.s2.rd; // RULE15
            if (st_r.s2.vld && !st_r.s2.rd)
            begin
                st_nxt.wdata = pin_word; // RULE9 RULE15
            end

            // pins driven only in the data cycle of a read; a deselect or
            // a write leaves them floating in that cycle
            st_nxt.drive = st_r.s2.vld && st_r.s2.rd; // RULE5 RULE12 RULE22
            if (st_r.s2.vld && st_r.s2.rd && rq.out_valid)
            begin
                st_nxt.dout = rq.out_data; // RULE15
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // array commit: one cycle after the data was registered
    always_ff @(posedge clk_sys_in)
    begin
        if (run && st_r.wr.vld)
        begin
            for (int b = 0; b < LANES; b++)
            begin
                if (!st_r.wr.bwn[b])
                begin
                    mem[st_r.wr.addr][b*LANE_W +: LANE_W] <= st_r.wdata[b*LANE_W +: LANE_W]; // RULE9
                end
            end
        end
    end

endmodule : sram_port

// *** design/word_fifo.sv ***
// first-in first-out word buffer with valid/ready on both sides
// assumes a synchronous active-low reset; push and pop may share an edge
`timescale 1ns/10ps
module word_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // both sides of the buffer
    fifo_link_if.fifo link
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW:0] wp;
        logic [PW:0] rp;
    } state_t;

    state_t       st_r;
    state_t       st_nxt;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_chk
        $error("word_fifo: DEPTH must be a power of two, at least 2");
    end

    // full when pointers differ only in the wrap bit
    assign link.in_ready  = (st_r.wp[PW-1:0] != st_r.rp[PW-1:0]) || (st_r.wp[PW] == st_r.rp[PW]);
    assign link.out_valid = (st_r.wp != st_r.rp);
    assign link.out_data  = mem[st_r.rp[PW-1:0]];
    assign push           = link.in_valid && link.in_ready;
    assign pop            = link.out_valid && link.out_ready;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // storage is not reset; pointers alone define what is valid
    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            mem[st_r.wp[PW-1:0]] <= link.in_data;
        end
    end

endmodule : word_fifo

// *** pkg/fifo_link_if.sv ***
// valid/ready link between a producer, a fifo and a consumer
// assumes both sides run on the same clock as the fifo
`timescale 1ns/10ps
interface fifo_link_if #(
    parameter int W = 36
) ();
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fifo (
        input  in_valid,
        input  in_data,
        input  out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );

    modport user (
        output in_valid,
        output in_data,
        output out_ready,
        input  in_ready,
        input  out_valid,
        input  out_data
    );
endinterface : fifo_link_if

// *** pkg/sram_port_pkg.sv ***
// constants and types shared by the pipelined static memory port
// assumes one clock; the host samples and drives on the same falling edge
package sram_port_pkg;

    // word layout: four lanes of eight data bits plus one parity bit
    localparam int LANES      = 4;
    localparam int BYTE_W     = 8;
    localparam int LANE_W     = 9;
    localparam int PAR_POS    = 8;
    localparam int DATA_W     = LANES * BYTE_W;
    localparam int WORD_W     = LANES * LANE_W;

    // array depth and burst
    localparam int ADDR_W_DEF = 17;
    localparam int BURST_W    = 2;
    localparam int FIFO_DEPTH = 8;

    localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
    localparam logic [LANES-1:0]   LANES_OFF   = 4'hF;

    // burst counter activity
    typedef enum logic {
        BURST_IDLE,
        BURST_RUN
    } burst_t;

endpackage : sram_port_pkg

// *** sim/host_bus_model.sv ***
// host controller model: drives the synchronous pins and the data wires
// assumes registered device outputs; one request per edge, driven at falling edge
`timescale 1ns/10ps
module host_bus_model #(parameter int ADDR_W = 17) (
    // control to the device
    input  wire logic              clk_sys_in,
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   ld_out, rw_out, hold_n_out, order_out, oen_out,
    output logic [3:0]             bwn_out,
    output logic [2:0]             sel_out,
    // resolved data wires
    output logic [31:0]            data_out,
    output logic [3:0]             par_out,
    input  wire logic [31:0]       rd_data_in,
    input  wire logic [3:0]        rd_par_in,
    input  wire logic              rd_oe_in
);
    logic [37:0] op_c, s1, s2, s3;
    logic [35:0] wd, flt;
    logic        drv, moved;
    logic [36:0] rdq[$];

    initial
    begin
        {op_c, s1, s2, s3, drv, moved, addr_out, wd} = '0;
        {ld_out, rw_out, hold_n_out, order_out, oen_out} = 5'h18;
        {bwn_out, sel_out} = 7'h7D;
        flt = 36'h5_A5A5_A5A5;
    end
    // nobody driving: wires wander, never keep the last word
    assign {par_out, data_out} = drv ? wd : (rd_oe_in ? {rd_par_in, rd_data_in} : flt);
    always @(posedge clk_sys_in)
    begin
        moved <= !hold_n_out;
        if (!hold_n_out)
        begin
            {s3, s2, s1} <= {s2, s1, op_c};
        end
    end
    always @(negedge clk_sys_in)
    begin
        // any drive outside a read slot also lands here, so a stray word shows up in the count
        if (moved && (s3[37:36] == 2'h1 || rd_oe_in))
        begin
            rdq.push_back({rd_oe_in, rd_par_in, rd_data_in});
        end
        drv <= s2[37:36] == 2'h2;
        wd <= s2[35:0];
        flt <= ~flt;
    end
    task automatic cyc(input logic [1:0] kind, input logic ld, rw, input logic [ADDR_W-1:0] a,
                       input logic [2:0] sel = 3'h1, input logic hold = 1'b0,
                       input logic [3:0] bwn = 4'h0, input logic [35:0] w = 36'h0);
        @(negedge clk_sys_in);
        op_c <= {kind, w};
        {ld_out, rw_out, hold_n_out, addr_out, sel_out} <= {ld, rw, hold, a, sel};
        bwn_out <= bwn;
    endtask : cyc
endmodule : host_bus_model

// *** sim/sram_port_asserts.sv ***
// pin-level checks for the pipelined memory port
// assumes one clock and the synchronous active-low reset of the port
`timescale 1ns/10ps
module sram_port_asserts #(parameter int ADDR_W = 17) (
    input wire logic clk_sys_in, rstn_in, load_or_advance_in, read_write_in, clock_hold_n_in,
    input wire logic chip_select_a_n_in, chip_select_b_n_in, chip_select_hi_in, burst_order_sel_in,
    input wire logic output_enable_n_in, data_lines_oe_out, parity_lines_oe_out,
    input wire logic [ADDR_W-1:0] addr_lines_in,
    input wire logic [3:0] byte_write_n_in, parity_lines_in, parity_lines_out,
    input wire logic [31:0] data_lines_in, data_lines_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    logic go, sel, shown;
    assign go = !clock_hold_n_in;
    assign sel = !chip_select_a_n_in && !chip_select_b_n_in && chip_select_hi_in;
    // oe gated off by the host still counts, the gate is checked apart
    assign shown = data_lines_oe_out || output_enable_n_in;
    sequence s_rd; go && !load_or_advance_in && sel && read_write_in; endsequence
    sequence s_wr; go && !load_or_advance_in && sel && !read_write_in; endsequence
    sequence s_off; go && !load_or_advance_in && !sel; endsequence
    property p_rd_lat; s_rd ##1 go ##1 go |=> shown; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read word late");
    property p_wr_float; s_wr ##1 go ##1 go |=> !data_lines_oe_out; endproperty
    a_wr_float: assert property (p_wr_float) else $error("driving in write slot");
    property p_off_float; s_off ##1 go ##1 go |=> !data_lines_oe_out; endproperty
    a_off_float: assert property (p_off_float) else $error("driving after deselect");
    property p_gate; output_enable_n_in |-> !data_lines_oe_out && !parity_lines_oe_out; endproperty
    a_gate: assert property (p_gate) else $error("pins driven with oe high");
    property p_hold; !go |=> $stable(data_lines_out) && $stable(parity_lines_out); endproperty
    a_hold: assert property (p_hold) else $error("outputs moved on held edge");
    property p_lanes; data_lines_oe_out == parity_lines_oe_out; endproperty
    a_lanes: assert property (p_lanes) else $error("parity and data drive differ");
    property p_burst; s_rd ##1 (go && load_or_advance_in) [*3] ##1 go ##1 go |=> shown; endproperty
    a_burst: assert property (p_burst) else $error("fourth burst word missing");
    property p_pend; s_rd ##1 s_off ##1 go |=> shown; endproperty
    a_pend: assert property (p_pend) else $error("deselect cancelled read");
    c_burst: cover property (s_rd ##1 (go && load_or_advance_in) [*3]);
    c_hold: cover property (s_rd ##1 !go);
    c_off: cover property (s_rd ##1 s_off);
endmodule : sram_port_asserts
bind sram_port sram_port_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** sim/tb_top.sv ***
// self-checking bench for the pipelined memory port
// assumes host_bus_model on the far side and the bound pin checker
`timescale 1ns/10ps
module tb_top;
    import sram_port_pkg::*;
    localparam int AW = 17;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [AW-1:0] addr_lines_in;
    logic load_or_advance_in, read_write_in, clock_hold_n_in, chip_select_a_n_in, chip_select_b_n_in;
    logic chip_select_hi_in, burst_order_sel_in, output_enable_n_in, data_lines_oe_out, parity_lines_oe_out;
    logic [3:0] byte_write_n_in, parity_lines_in, parity_lines_out;
    logic [31:0] data_lines_in, data_lines_out;
    logic [35:0] ref_mem[int];
    logic [36:0] expq[$];
    int error_cnt = 0;
    int cmp_count = 0;
    int ticks = 0;

    always #25 clk_sys_in = ~clk_sys_in;
    sram_port #(.ADDR_W(AW)) u_dut (.*);
    host_bus_model #(.ADDR_W(AW)) u_host (.clk_sys_in, .addr_out(addr_lines_in), .ld_out(load_or_advance_in),
        .rw_out(read_write_in), .hold_n_out(clock_hold_n_in), .order_out(burst_order_sel_in),
        .oen_out(output_enable_n_in), .bwn_out(byte_write_n_in), .data_out(data_lines_in),
        .sel_out({chip_select_a_n_in, chip_select_b_n_in, chip_select_hi_in}), .par_out(parity_lines_in),
        .rd_data_in(data_lines_out), .rd_par_in(parity_lines_out), .rd_oe_in(data_lines_oe_out));
    always @(posedge clk_sys_in)
    begin
        ticks++;
        if (ticks == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [AW-1:0] a, input logic [35:0] w, input logic [3:0] bwn);
        logic [35:0] m;
        m = ref_mem.exists(a) ? ref_mem[a] : 36'h0;
        for (int b = 0; b < LANES; b++)
        begin
            if (!bwn[b])
            begin
                m[8*b+:8] = w[8*b+:8];
                m[32+b] = w[32+b];
            end
        end
        ref_mem[a] = m;
        u_host.cyc(2'h2, 1'b0, 1'b0, a, 3'h1, 1'b0, bwn, w);
    endtask : wr
    task automatic rd(input logic [AW-1:0] a);
        u_host.cyc(2'h1, 1'b0, 1'b1, a);
        expq.push_back({1'b1, ref_mem[a]});
    endtask : rd
    task automatic off(input logic [2:0] sel);
        u_host.cyc(2'h0, 1'b0, 1'b1, 17'h0, sel);
    endtask : off
    task automatic settle(input string name);
        repeat (4) off(3'h5);
        cmp({name, " words"}, expq.size(), u_host.rdq.size());
        while (expq.size() > 0 && u_host.rdq.size() > 0)
        begin
            cmp(name, expq.pop_front(), u_host.rdq.pop_front());
        end
        expq.delete();
        u_host.rdq.delete();
        $display("test %s done", name);
    endtask : settle
    // advances carry the inverse address and read/write kind, both must be ignored
    task automatic burst(input logic [1:0] kind, input logic ord, input logic [AW-1:0] base);
        logic [AW-1:0] a;
        for (int n = 0; n < 4; n++)
        begin
            a = base;
            a[1:0] = ord ? base[1:0] ^ 2'(n) : base[1:0] + 2'(n);
            if (kind == 2'h2)
            begin
                ref_mem[a] = 36'h9_6000_0000 ^ 36'(a);
            end
            else
            begin
                expq.push_back({1'b1, ref_mem[a]});
            end
            u_host.cyc(kind, n != 0, (kind == 2'h1) ^ (n != 0), n == 0 ? base : ~base, 3'h1, 1'b0, 4'h0,
                       36'h9_6000_0000 ^ 36'(a));
        end
    endtask : burst
    initial
    begin
        repeat (16) @(negedge clk_sys_in);
        rstn_in <= 1'b1;
        cmp("oe in reset", 1'b0, data_lines_oe_out);
        for (int i = 0; i < 4; i++)
        begin
            wr(17'h10 + 17'(i), 36'hA_1234_5670 + 36'(i), 4'h0);
        end
        rd(17'h10);
        wr(17'h14, 36'h5_0F0F_0F0F, 4'h0);
        rd(17'h14);
        rd(17'h13);
        settle("back to back");
        for (int b = 0; b < 4; b++)
        begin
            wr(17'h28 + 17'(b), 36'hF_FFFF_FFFF, 4'h0);
            wr(17'h28 + 17'(b), 36'h0, ~(4'h1 << b));
            rd(17'h28 + 17'(b));
            rd(17'h28 + 17'(b));
        end
        settle("byte lanes");
        for (int o = 0; o < 2; o++)
        begin
            @(negedge clk_sys_in);
            u_host.order_out <= o[0];
            burst(2'h2, o[0], 17'h42);
            burst(2'h1, o[0], 17'h41);
            settle("burst");
        end
        for (int i = 0; i < 3; i++)
        begin
            rd(17'h10);
            off(3'h1 ^ (3'h4 >> i));
            u_host.cyc(2'h0, 1'b1, 1'b1, 17'h0);
        end
        settle("deselect");
        rd(17'h10);
        repeat (3) u_host.cyc(2'h0, 1'b0, 1'b0, 17'h12, 3'h1, 1'b1);
        rd(17'h11);
        rd(17'h12);
        settle("clock hold");
        rd(17'h10);
        off(3'h5);
        off(3'h5);
        u_host.oen_out <= 1'b1;
        expq[0][36] = 1'b0;
        off(3'h5);
        u_host.oen_out <= 1'b0;
        settle("output enable");
        complete_run();
    end
endmodule : tb_top
